// [bench/tng_far_end.sv]
// far-side terminal equipment model supplying payload nibbles
`timescale 1ns/10ps
module tng_far_end
(
    input  wire logic       sys_rst,
    input  wire logic       gapped,
    input  wire logic [3:0] step,
    input  wire logic       tx_nibble_clock,
    input  wire logic       overhead_demand_clock_out,
    output logic      [3:0] tx_payload_nibble_in
);
    logic [3:0] exp_q[$];
    logic       hold_reg;

    initial
    begin
        tx_payload_nibble_in = 4'h0;
        hold_reg             = 1'b1;
    end

    // every nibble put on the pins is one capture the bench expects
    task automatic advance();
        logic [3:0] nxt;
        nxt = tx_payload_nibble_in + step;
        tx_payload_nibble_in <= nxt;
        exp_q.push_back(nxt);
    endtask

    always @(posedge sys_rst)
    begin
        exp_q.delete();
        hold_reg <= 1'b1;
    end

    // no status pin consulted in gapped mode
    always @(posedge overhead_demand_clock_out)
    begin
        if (gapped)
            advance();
    end

    // the clock falling because of reset is not a slot end
    always @(negedge tx_nibble_clock)
    begin
        if (!sys_rst)
            hold_reg <= overhead_demand_clock_out;
    end

    always @(posedge tx_nibble_clock)
    begin
        if (!gapped && !hold_reg)
            advance();
    end
endmodule

// [bench/tng_top_tb.sv]
// self-checking bench for the gapped demand clock payload input
`timescale 1ns/10ps
module tng_top_tb;
    import tng_pkg::*;
    localparam int SD = 4;
    localparam int LIMIT = 20000;
    logic        ref_clk = 1'b0;
    logic        tx_input_clock = 1'b0;
    logic        rx_recovered_clock = 1'b0;
    logic        sys_rst, reg_wr, reg_rd, gapped, rd_seen;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, v;
    logic [3:0]  tx_payload_nibble_in, payload_nibble_out, step;
    logic        overhead_demand_clock_out, tx_nibble_clock, payload_valid;
    logic        rx_demand_clock_enable, overhead_source_select;
    logic        prbs_det_enable, prbs_gen_enable;
    logic [7:0]  rd_q[$];
    int          miscompares, checks_done, cycles, r, h, n;
    realtime     g;

    always #5 ref_clk = ~ref_clk;
    always #18 rx_recovered_clock = ~rx_recovered_clock;
    // link clock offset so its edges never line up with ref_clk
    initial #2.5 forever #6 tx_input_clock = ~tx_input_clock;

    tng_top #(.SLOT_DIV(SD), .HIGH_CYC(2)) dut_u (.*);
    tng_far_end far_u (.*);

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask

    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic rd, input logic [15:0] a, input logic [7:0] d);
        reg_wr    <= wr;
        reg_rd    <= rd;
        reg_addr  <= a;
        reg_wdata <= d;
        if (rd)
            rd_q.push_back(d);
        @(posedge ref_clk);
    endtask

    // any window of one frame length holds every nibble slot of the frame exactly once
    task automatic frame_count(output int rises, output int highs, output int nrises);
        logic pd;
        logic pn;
        rises = 0;
        highs = 0;
        nrises = 0;
        @(posedge tx_input_clock);
        pd = overhead_demand_clock_out;
        pn = tx_nibble_clock;
        repeat (FRAME_BYTES * 2 * SD)
        begin
            @(posedge tx_input_clock);
            rises += int'(overhead_demand_clock_out && !pd);
            nrises += int'(tx_nibble_clock && !pn);
            highs += int'(overhead_demand_clock_out);
            pd = overhead_demand_clock_out;
            pn = tx_nibble_clock;
        end
    endtask

    task automatic min_gap(output realtime gap);
        realtime t0;
        gap = 1.0e9;
        @(posedge overhead_demand_clock_out);
        repeat (4)
        begin
            t0 = $realtime;
            @(posedge overhead_demand_clock_out);
            if ($realtime - t0 < gap)
                gap = $realtime - t0;
        end
    endtask

    always @(posedge ref_clk)
    begin
        if (rd_seen && rd_q.size() > 0)
            check(reg_rdata, rd_q.pop_front());
        rd_seen <= reg_rd;
        if (payload_valid === 1'b1)
        begin
            if (far_u.exp_q.size() == 0)
                check(32'h1, 32'h0);
            else
                check(payload_nibble_out, far_u.exp_q.pop_front());
        end
        cycles++;
        if (cycles == LIMIT)
        begin
            miscompares++;
            summarize();
        end
    end

    initial
    begin
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        rd_seen = 1'b0;
        gapped = 1'b0;
        void'($urandom(32'h8832));
        step = 4'($urandom()) | 4'h1;
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        bus(1'b0, 1'b1, FTC_ADDR, FTC_RESET);
        bus(1'b1, 1'b0, FTC_ADDR, 8'h20);
        bus(1'b0, 1'b1, FTC_ADDR, 8'h20);
        bus(1'b0, 1'b1, 16'h1234, 8'h00);
        bus(1'b0, 1'b0, 16'h0000, 8'h00);
        // indicator level right after reset is not a demand edge
        gapped <= 1'b1;
        check(rx_demand_clock_enable, 1'b0);
        frame_count(r, h, n);
        check(r, PAYLOAD_BYTES * 2);
        check(n, FRAME_BYTES * 2);
        min_gap(g);
        check(int'(g), SD * 12);
        bus(1'b1, 1'b0, TIMING_ADDR, 8'h01);
        bus(1'b0, 1'b1, TIMING_ADDR, 8'h01);
        bus(1'b0, 1'b0, 16'h0000, 8'h00);
        repeat (200) @(posedge tx_input_clock);
        min_gap(g);
        check(g >= 132.0 && g <= 156.0, 1'b1);
        // second run: overhead indicator role
        sys_rst <= 1'b1;
        gapped <= 1'b0;
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        bus(1'b0, 1'b1, STATUS_ADDR, 8'h00);
        v = 8'($urandom()) & 8'hdf;
        bus(1'b1, 1'b0, FTC_ADDR, v);
        bus(1'b0, 1'b1, FTC_ADDR, v & FTC_WMASK);
        bus(1'b0, 1'b1, TIMING_ADDR, TIMING_RESET);
        bus(1'b0, 1'b0, 16'h0000, 8'h00);
        repeat (2) @(posedge ref_clk);
        check({overhead_source_select, rx_demand_clock_enable}, v[7:6]);
        check({prbs_det_enable, prbs_gen_enable}, v[3:2]);
        frame_count(r, h, n);
        check(h, OH_BYTES * 2 * SD);
        check(n, FRAME_BYTES * 2);
        repeat (50) @(posedge ref_clk);
        check(far_u.exp_q.size() <= 1, 1'b1);
        summarize();
    end
endmodule

// [core/tng_pkg.sv]
// constants and types for the transmit nibble gapped-clock payload input
// Behaviour
// [R01]: gapped mode turns indicator pin into demand clock
// [R02]: demand pulse only when ready for payload
// [R03]: no demand pulse for overhead nibbles
// [R04]: far side changes nibble on demand rise
// [R05]: nibble captured on demand clock falling edge
// [R06]: far side needs no status gating
// [R07]: loop timing paces from recovered line clock
// [R08]: local timing paces from transmit input clock
// [R09]: bit 5 at 0x110c enables gapped mode
// [R10]: transmit enable separate from receive gapped enable
// [R11]: frame is 537 bytes, 530 payload, 7 overhead
// [R12]: port accepts payload nibbles only
// [R13]: far side holds nibble while indicator high
// [R14]: enable low keeps overhead indicator role
package tng_pkg;

    localparam logic [15:0] FTC_ADDR    = 16'h110c;
    localparam logic [15:0] TIMING_ADDR = 16'h1110;
    localparam logic [15:0] STATUS_ADDR = 16'h1111;

    localparam int OH_SRC_BIT   = 7;
    localparam int RX_GAP_BIT   = 6;
    localparam int TX_GAP_BIT   = 5;
    localparam int PRBS_DET_BIT = 3;
    localparam int PRBS_GEN_BIT = 2;
    localparam int LOOP_BIT     = 0;

    localparam logic [7:0] FTC_RESET    = 8'h00;
    localparam logic [7:0] FTC_WMASK    = 8'hec;
    localparam logic [7:0] TIMING_RESET = 8'h00;
    localparam logic [7:0] TIMING_WMASK = 8'h01;

    localparam int FRAME_BYTES   = 537;
    localparam int PAYLOAD_BYTES = 530;
    localparam int OH_BYTES      = FRAME_BYTES - PAYLOAD_BYTES;

    localparam int NIB_W = 11;
    localparam logic [NIB_W-1:0] NIB_LAST = NIB_W'(FRAME_BYTES * 2 - 1);
    localparam logic [NIB_W-1:0] OH_NIBS  = NIB_W'(OH_BYTES * 2);

    localparam int SLOT_CYCLES = 4;
    localparam int HIGH_CYCLES = 2;
    localparam int CNT_W       = 4;

    typedef enum logic [2:0] {
        SL_WAIT = 3'b001,
        SL_HIGH = 3'b010,
        SL_CAPT = 3'b100
    } tng_slot_type;

endpackage

// [core/tng_top.sv]
// transmit payload nibble input with gapped demand clock
`timescale 1ns/10ps
module tng_top
#(
    parameter int SLOT_DIV = tng_pkg::SLOT_CYCLES,
    parameter int HIGH_CYC = tng_pkg::HIGH_CYCLES
)
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        tx_input_clock,
    input  wire logic        rx_recovered_clock,
    input  wire logic [3:0]  tx_payload_nibble_in,
    output logic             overhead_demand_clock_out,
    output logic             tx_nibble_clock,
    output logic      [3:0]  payload_nibble_out,
    output logic             payload_valid,
    output logic             rx_demand_clock_enable,
    output logic             overhead_source_select,
    output logic             prbs_det_enable,
    output logic             prbs_gen_enable
);
    import tng_pkg::*;

    function automatic logic oh_slot(input logic [NIB_W-1:0] idx);
        oh_slot = (idx < OH_NIBS);
    endfunction

    function automatic logic [NIB_W-1:0] next_idx(input logic [NIB_W-1:0] idx);
        next_idx = (idx == NIB_LAST) ? '0 : NIB_W'(idx + 1'b1);
    endfunction

    // register side, ref_clk domain
    logic [7:0] ftc_reg;
    logic [7:0] ftc_next;
    logic [7:0] timing_reg;
    logic [7:0] timing_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [3:0] nib_out_reg;
    logic [3:0] nib_out_next;
    logic       valid_reg;
    logic       valid_next;
    logic       tog_s1_reg;
    logic       tog_s2_reg;
    logic       tog_s3_reg;

    // link side, tx_input_clock domain
    logic             lrst_m_reg;
    logic             lrst_reg;
    logic             gap_s1_reg;
    logic             gap_s2_reg;
    logic             loop_s1_reg;
    logic             loop_s2_reg;
    logic             rec_s1_reg;
    logic             rec_s2_reg;
    logic             rec_prev_reg;
    logic [3:0]       din_s1_reg;
    logic [3:0]       din_s2_reg;
    tng_slot_type     state_reg;
    tng_slot_type     state_next;
    logic [CNT_W-1:0] div_reg;
    logic [CNT_W-1:0] div_next;
    logic [CNT_W-1:0] hcnt_reg;
    logic [CNT_W-1:0] hcnt_next;
    logic [NIB_W-1:0] nib_reg;
    logic [NIB_W-1:0] nib_next;
    logic             nclk_reg;
    logic             nclk_next;
    logic             dem_reg;
    logic             dem_next;
    logic [3:0]       cap_reg;
    logic [3:0]       cap_next;
    logic             tog_reg;
    logic             tog_next;
    logic             pace_ev;
    logic             tick;

    always_comb
    begin
        ftc_next     = ftc_reg;
        timing_next  = timing_reg;
        rdata_next   = 8'h00;
        nib_out_next = nib_out_reg;
        valid_next   = 1'b0;
        if (reg_wr && reg_addr == FTC_ADDR)
        begin
            ftc_next = reg_wdata & FTC_WMASK; // [R09] [R10]
        end
        else if (reg_wr && reg_addr == TIMING_ADDR)
        begin
            timing_next = reg_wdata & TIMING_WMASK;
        end
        if (reg_rd && reg_addr == FTC_ADDR)
        begin
            rdata_next = ftc_reg;
        end
        else if (reg_rd && reg_addr == TIMING_ADDR)
        begin
            rdata_next = timing_reg;
        end
        else if (reg_rd && reg_addr == STATUS_ADDR)
        begin
            rdata_next = {4'h0, nib_out_reg};
        end
        // captured word is stable for a whole slot after its toggle
        if (tog_s2_reg != tog_s3_reg)
        begin
            nib_out_next = cap_reg;
            valid_next   = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ftc_reg     <= FTC_RESET;
            timing_reg  <= TIMING_RESET;
            rdata_reg   <= 8'h00;
            nib_out_reg <= 4'h0;
            valid_reg   <= 1'b0;
            tog_s1_reg  <= 1'b0;
            tog_s2_reg  <= 1'b0;
            tog_s3_reg  <= 1'b0;
        end
        else
        begin
            ftc_reg     <= ftc_next;
            timing_reg  <= timing_next;
            rdata_reg   <= rdata_next;
            nib_out_reg <= nib_out_next;
            valid_reg   <= valid_next;
            tog_s1_reg  <= tog_reg;
            tog_s2_reg  <= tog_s1_reg;
            tog_s3_reg  <= tog_s2_reg;
        end
    end

    assign reg_rdata              = rdata_reg;
    assign payload_nibble_out     = nib_out_reg;
    assign payload_valid          = valid_reg;
    assign rx_demand_clock_enable = ftc_reg[RX_GAP_BIT]; // [R10]
    assign overhead_source_select = ftc_reg[OH_SRC_BIT];
    assign prbs_det_enable        = ftc_reg[PRBS_DET_BIT];
    assign prbs_gen_enable        = ftc_reg[PRBS_GEN_BIT];

    // slot pacing: loop timing counts recovered edges, local counts input clocks
    always_comb
    begin
        pace_ev    = loop_s2_reg ? (rec_s2_reg & ~rec_prev_reg) : 1'b1; // [R07] [R08]
        tick       = pace_ev && (div_reg == CNT_W'(SLOT_DIV - 1));
        div_next   = div_reg;
        state_next = state_reg;
        hcnt_next  = hcnt_reg;
        nib_next   = nib_reg;
        nclk_next  = nclk_reg;
        cap_next   = cap_reg;
        tog_next   = tog_reg;
        if (pace_ev)
        begin
            div_next = tick ? '0 : CNT_W'(div_reg + 1'b1);
        end
        case (state_reg)
            SL_WAIT:
            begin
                if (tick)
                begin
                    state_next = SL_HIGH;
                    hcnt_next  = '0;
                    nclk_next  = 1'b1;
                end
            end
            SL_HIGH:
            begin
                hcnt_next = CNT_W'(hcnt_reg + 1'b1);
                if (hcnt_reg == CNT_W'(HIGH_CYC - 1))
                begin
                    state_next = SL_CAPT;
                    nclk_next  = 1'b0;
                end
            end
            SL_CAPT:
            begin
                // one cycle after the fall, so the synchronised nibble has settled
                if (!oh_slot(nib_reg))
                begin
                    cap_next = din_s2_reg; // [R05] [R12]
                    tog_next = ~tog_reg;
                end
                nib_next   = next_idx(nib_reg); // [R11]
                state_next = SL_WAIT;
            end
            default:
            begin
                state_next = SL_WAIT;
                nclk_next  = 1'b0;
            end
        endcase
        if (gap_s2_reg)
        begin
            dem_next = nclk_next & ~oh_slot(nib_next); // [R01] [R02] [R03]
        end
        else
        begin
            // warns the far side that the following slot is overhead
            dem_next = oh_slot(next_idx(nib_next)); // [R14]
        end
    end

    always_ff @(posedge tx_input_clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            lrst_m_reg   <= 1'b1;
            lrst_reg     <= 1'b1;
        end
        else
        begin
            lrst_m_reg   <= 1'b0;
            lrst_reg     <= lrst_m_reg;
        end
    end

    always_ff @(posedge tx_input_clock or posedge lrst_reg)
    begin
        if (lrst_reg)
        begin
            gap_s1_reg   <= 1'b0;
            gap_s2_reg   <= 1'b0;
            loop_s1_reg  <= 1'b0;
            loop_s2_reg  <= 1'b0;
            rec_s1_reg   <= 1'b0;
            rec_s2_reg   <= 1'b0;
            rec_prev_reg <= 1'b0;
            din_s1_reg   <= 4'h0;
            din_s2_reg   <= 4'h0;
            state_reg    <= SL_WAIT;
            div_reg      <= '0;
            hcnt_reg     <= '0;
            nib_reg      <= '0;
            nclk_reg     <= 1'b0;
            dem_reg      <= 1'b0;
            cap_reg      <= 4'h0;
            tog_reg      <= 1'b0;
        end
        else
        begin
            gap_s1_reg   <= ftc_reg[TX_GAP_BIT];
            gap_s2_reg   <= gap_s1_reg;
            loop_s1_reg  <= timing_reg[LOOP_BIT];
            loop_s2_reg  <= loop_s1_reg;
            rec_s1_reg   <= rx_recovered_clock;
            rec_s2_reg   <= rec_s1_reg;
            rec_prev_reg <= rec_s2_reg;
            din_s1_reg   <= tx_payload_nibble_in;
            din_s2_reg   <= din_s1_reg;
            state_reg    <= state_next;
            div_reg      <= div_next;
            hcnt_reg     <= hcnt_next;
            nib_reg      <= nib_next;
            nclk_reg     <= nclk_next;
            dem_reg      <= dem_next;
            cap_reg      <= cap_next;
            tog_reg      <= tog_next;
        end
    end

    assign overhead_demand_clock_out = dem_reg;
    assign tx_nibble_clock           = nclk_reg;

    demand_role_a: assert property ( // [R01]
        @(posedge tx_input_clock) disable iff (lrst_reg)
        $past(gap_s2_reg) && $rose(nclk_reg) && !oh_slot(nib_reg) |-> dem_reg)
        else $error("demand clock missing in payload slot");

    pulse_only_ready_a: assert property ( // [R02]
        @(posedge tx_input_clock) disable iff (lrst_reg)
        $past(gap_s2_reg) && $rose(dem_reg) |-> nclk_reg && !oh_slot(nib_reg))
        else $error("demand pulse outside a payload slot");

    overhead_gap_a: assert property ( // [R03]
        @(posedge tx_input_clock) disable iff (lrst_reg)
        $past(gap_s2_reg) && nclk_reg && oh_slot(nib_reg) |-> !dem_reg)
        else $error("demand pulse during overhead slot");

    fall_capture_a: assert property ( // [R05]
        @(posedge tx_input_clock) disable iff (lrst_reg)
        $past(gap_s2_reg) && $past(gap_s2_reg, 2) && $fell(dem_reg)
        |=> cap_reg == $past(din_s2_reg) && tog_reg != $past(tog_reg))
        else $error("nibble not captured after demand fall");

    loop_pace_a: assert property ( // [R07]
        @(posedge tx_input_clock) disable iff (lrst_reg)
        $rose(nclk_reg) && $past(loop_s2_reg) |-> $past(rec_s2_reg && !rec_prev_reg))
        else $error("loop slot not paced by recovered clock");

    local_pace_a: assert property ( // [R08]
        @(posedge tx_input_clock) disable iff (lrst_reg)
        $rose(nclk_reg) && !$past(loop_s2_reg) |-> $past(div_reg) == CNT_W'(SLOT_DIV - 1))
        else $error("local slot not paced by input clock divider");

    enable_bit_a: assert property ( // [R09]
        @(posedge ref_clk) disable iff (sys_rst)
        reg_wr && reg_addr == FTC_ADDR |=> ftc_reg[TX_GAP_BIT] == $past(reg_wdata[TX_GAP_BIT]))
        else $error("transmit gapped enable not written");

    rx_separate_a: assert property ( // [R10]
        @(posedge ref_clk) disable iff (sys_rst)
        reg_wr && reg_addr == FTC_ADDR && reg_wdata[TX_GAP_BIT] != reg_wdata[RX_GAP_BIT]
        |=> rx_demand_clock_enable != ftc_reg[TX_GAP_BIT])
        else $error("receive gapped enable tied to transmit");

    frame_wrap_a: assert property ( // [R11]
        @(posedge tx_input_clock) disable iff (lrst_reg)
        state_reg == SL_CAPT && nib_reg == NIB_LAST |=> nib_reg == '0 && state_reg == SL_WAIT)
        else $error("frame nibble count does not wrap");

    payload_only_a: assert property ( // [R12]
        @(posedge tx_input_clock) disable iff (lrst_reg)
        state_reg == SL_CAPT && oh_slot(nib_reg) |=> tog_reg == $past(tog_reg))
        else $error("overhead slot captured as payload");

    indicator_role_a: assert property ( // [R14]
        @(posedge tx_input_clock) disable iff (lrst_reg)
        !$past(gap_s2_reg) && !$past(lrst_reg) && $past(state_reg) != SL_CAPT
        |-> dem_reg == oh_slot(next_idx(nib_reg)))
        else $error("indicator pin does not flag overhead");

endmodule
